/* testbench/ssp_port_props.sv */
// assertion checker for the serial port, bound to its top
`timescale 1ns/1ps
`default_nettype none
module ssp_port_props #(
  parameter DIV_W = 8
) (
  input wire logic I_MCLK,
  input wire logic I_RESETN,
  input wire logic I_MASTER_EN,
  input wire logic I_CPOL,
  input wire logic [DIV_W-1:0] I_DIV,
  input wire logic I_STATUS_RD,
  input wire logic O_RX_OVF,
  input wire logic O_TX_UNF,
  input wire logic O_IRQ,
  input wire logic O_BUSY,
  input wire logic O_SCLK,
  input wire logic O_SCLK_OE,
  input wire logic O_MISO_OE,
  input wire logic O_MOSI,
  input wire logic O_MOSI_OE,
  input wire logic O_SS_N,
  input wire logic O_SS_N_OE
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RESETN);
  logic sclk_q;
  logic [4:0] tcnt;
  logic [9:0] gap;
  wire tgl = O_SCLK != sclk_q;
  // divider values below one run as one
  wire [9:0] h = 10'(I_DIV) + ((I_DIV == '0) ? 10'h002 : 10'h001);
  always @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      sclk_q <= 1'b0;
      tcnt <= 5'h00;
      gap <= 10'h000;
    end else begin
      sclk_q <= O_SCLK;
      gap <= tgl ? 10'h001 : gap + 10'h001;
      tcnt <= O_SS_N ? 5'h00 : tcnt + {4'h0, tgl};
    end
  end
  property p_mosi_oe;
    $past(I_RESETN) |-> O_MOSI_OE == $past(I_MASTER_EN);
  endproperty
  a_mosi_oe: assert property (p_mosi_oe) else $error("mosi enable wrong");
  property p_miso_oe;
    $past(I_RESETN) |-> O_MISO_OE == !$past(I_MASTER_EN);
  endproperty
  a_miso_oe: assert property (p_miso_oe) else $error("miso enable wrong");
  property p_sclk_oe;
    $past(I_RESETN) |-> O_SCLK_OE == $past(I_MASTER_EN);
  endproperty
  a_sclk_oe: assert property (p_sclk_oe) else $error("sclk enable wrong");
  property p_ss_oe;
    $past(I_RESETN) |-> O_SS_N_OE == $past(I_MASTER_EN);
  endproperty
  a_ss_oe: assert property (p_ss_oe) else $error("select enable wrong");
  // idle level may lag a polarity change by two clocks
  property p_idle_clk;
    O_SCLK_OE && O_SS_N && $past(I_RESETN, 2) && $past(I_CPOL, 2) == I_CPOL
      |-> O_SCLK == I_CPOL;
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("idle clock level");
  property p_frame;
    O_SS_N_OE && $rose(O_SS_N) |-> tcnt == 5'h10;
  endproperty
  a_frame: assert property (p_frame) else $error("edge count per byte");
  property p_half;
    O_SS_N_OE && !O_SS_N && tgl && tcnt != 5'h00 |-> gap == h;
  endproperty
  a_half: assert property (p_half) else $error("half period length");
  property p_mosi_launch;
    O_MOSI_OE && !O_SS_N && $past(!O_SS_N) && !$stable(O_MOSI)
      |-> tgl || $past(tgl);
  endproperty
  a_mosi_launch: assert property (p_mosi_launch) else $error("mosi moved off edge");
  property p_clear;
    I_STATUS_RD && !O_BUSY |-> ##[1:2] !(O_RX_OVF || O_TX_UNF || O_IRQ);
  endproperty
  a_clear: assert property (p_clear) else $error("flags not cleared");
  c_frame: cover property (O_SS_N_OE && $rose(O_SS_N));
  c_unf: cover property ($rose(O_TX_UNF));
  c_ovf: cover property ($rose(O_RX_OVF));
endmodule // ssp_port_props
bind ssp_port ssp_port_props #(.DIV_W(DIV_W)) u_props (.*);
`default_nettype wire

/* testbench/ssp_port_tb_top.sv */
// self-checking bench for the serial port
`timescale 1ns/1ps
`default_nettype none
module ssp_port_tb_top;
  logic I_MCLK = 1'b0;
  logic I_RESETN = 1'b0;
  logic I_MASTER_EN, I_CPOL, I_CPHA, I_XFER_INIT_MODE, I_RX_FLUSH_EN;
  logic I_TX_FLUSH_EN, I_TX_WR, I_RX_RD, I_STATUS_RD;
  logic [7:0] I_DIV, I_TX_DATA, slv_byte;
  logic [1:0] I_IRQ_BYTES;
  logic tb_sclk, tb_mosi, tb_ss_n;
  wire [7:0] O_RX_DATA, m_rx;
  wire [2:0] O_RX_LEVEL, O_TX_LEVEL;
  wire O_RX_OVF, O_TX_UNF, O_RX_IRQ, O_TX_IRQ, O_IRQ, O_BUSY, m_miso;
  wire O_SCLK, O_SCLK_OE, O_MISO, O_MISO_OE, O_MOSI, O_MOSI_OE;
  wire O_SS_N, O_SS_N_OE;
  wire sclk_w = O_SCLK_OE ? O_SCLK : tb_sclk;
  wire mosi_w = O_MOSI_OE ? O_MOSI : tb_mosi;
  wire ss_w = O_SS_N_OE ? O_SS_N : tb_ss_n;
  wire miso_w = O_MISO_OE ? O_MISO : m_miso;
  int miscompares = 0;
  int samples_checked = 0;
  always #25 I_MCLK = ~I_MCLK;
  // each pin loops back the port's own driver when enabled, else the bench or slave model drives it
  ssp_port u_dut (.*, .I_SCLK(sclk_w), .I_MISO(miso_w), .I_MOSI(mosi_w),
    .I_SS_N(ss_w));
  ssp_slave_model u_slave (.i_sclk(sclk_w), .i_ss_n(ss_w), .i_mosi(mosi_w),
    .i_cpol(I_CPOL), .i_cpha(I_CPHA), .i_byte(slv_byte), .o_miso(m_miso),
    .o_rx(m_rx));
  task wrap_up;
    $display("compared %0d, mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task tick(input int n);
    repeat (n) @(negedge I_MCLK);
  endtask
  task do_reset(input logic ms, input logic [1:0] md, input logic [7:0] dv,
    input logic xm);
    I_RESETN = 1'b0;
    I_MASTER_EN = ms;
    {I_CPOL, I_CPHA} = md;
    I_DIV = dv;
    I_XFER_INIT_MODE = xm;
    tick(2);
    I_RESETN = 1'b1;
    tick(2);
  endtask
  task push(input logic [7:0] d);
    I_TX_DATA = d;
    I_TX_WR = 1'b1;
    tick(1);
    I_TX_WR = 1'b0;
    tick(1);
  endtask
  task rd_pulse(input logic st);
    if (st) I_STATUS_RD = 1'b1;
    else I_RX_RD = 1'b1;
    tick(1);
    I_STATUS_RD = 1'b0;
    I_RX_RD = 1'b0;
    tick(2);
  endtask
  // a frame is done when the select returns high
  task wait_frames(input int n);
    int k;
    int c;
    logic p;
    c = 0;
    p = ss_w;
    for (k = 0; k < 4000 && c < n; k++) begin
      tick(1);
      if (ss_w && !p) c++;
      p = ss_w;
    end
    if (c < n) begin
      miscompares++;
      $display("unexpected frame count: expected %0d seen %0d", n, c);
      wrap_up();
    end
    tick(4);
  endtask
  task t_reset_vals;
    do_reset(1'b1, 2'h0, 8'h04, 1'b1);
    chk("select idle", 8'h01, O_SS_N);
    chk("sclk idle", 8'h00, O_SCLK);
    chk("busy", 8'h00, O_BUSY);
    chk("tx level", 8'h00, O_TX_LEVEL);
  endtask
  // all four clock modes; divider zero is clamped to the fastest rate
  task t_master;
    logic [1:0] m;
    logic [7:0] tx;
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      do_reset(1'b1, m, m[1] ? 8'h04 : 8'h00, 1'b1);
      slv_byte = 8'hC3 ^ {6'h00, m};
      tx = 8'h96 ^ {m, m, m, m};
      push(tx);
      wait_frames(1);
      chk("slave got", tx, m_rx);
      chk("master got", slv_byte, O_RX_DATA);
      chk("sclk back idle", {7'h00, m[1]}, O_SCLK);
      chk("tx count irq", 8'h01, O_TX_IRQ);
      chk("rx count irq", 8'h00, O_RX_IRQ);
      rd_pulse(1'b1);
      chk("irq after status", 8'h00, O_IRQ);
    end
  endtask
  task t_underflow;
    do_reset(1'b1, 2'h0, 8'h01, 1'b0);
    I_IRQ_BYTES = 2'h3;
    I_TX_FLUSH_EN = 1'b1;
    I_RX_FLUSH_EN = 1'b1;
    slv_byte = 8'h81;
    rd_pulse(1'b0);
    wait_frames(1);
    chk("fill byte", 8'h00, m_rx);
    chk("underflow", 8'h01, O_TX_UNF);
    chk("masked irq", 8'h00, O_IRQ);
    rd_pulse(1'b1);
    chk("underflow clear", 8'h00, O_TX_UNF);
    I_TX_FLUSH_EN = 1'b0;
    rd_pulse(1'b0);
    wait_frames(1);
    chk("underflow again", 8'h01, O_TX_UNF);
    chk("unmasked irq", 8'h01, O_IRQ);
    chk("early rx irq", 8'h00, O_RX_IRQ);
    chk("rx level", 8'h01, O_RX_LEVEL);
    I_RX_FLUSH_EN = 1'b0;
  endtask
  task t_overflow;
    do_reset(1'b1, 2'h3, 8'h02, 1'b1);
    slv_byte = 8'h4E;
    for (int k = 0; k < 4; k++) push(8'h10 + k[7:0]);
    wait_frames(4);
    chk("rx full", 8'h04, O_RX_LEVEL);
    chk("no overflow", 8'h00, O_RX_OVF);
    chk("tx count irq", 8'h01, O_TX_IRQ);
    push(8'h55);
    wait_frames(1);
    chk("overflow", 8'h01, O_RX_OVF);
    chk("rx still full", 8'h04, O_RX_LEVEL);
    rd_pulse(1'b1);
    chk("overflow clear", 8'h00, O_RX_OVF);
  endtask
  // bench plays master at one bit per microsecond, two bytes per select
  task t_slave;
    logic [1:0] m;
    logic [7:0] mb;
    logic [7:0] sb;
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      do_reset(1'b0, m, 8'h04, 1'b0);
      I_IRQ_BYTES = 2'h1;
      tb_sclk = m[1];
      push(8'hA5);
      push(8'h3C);
      tb_ss_n = 1'b0;
      tick(10);
      for (int j = 0; j < 2; j++) begin
        mb = j ? 8'h69 : 8'hD2;
        for (int b = 0; b < 8; b++) begin
          if (!m[0]) tb_mosi = mb[7 - b];
          tb_sclk = ~tb_sclk;
          if (m[0]) tb_mosi = mb[7 - b];
          else sb = {sb[6:0], miso_w};
          tick(10);
          tb_sclk = ~tb_sclk;
          if (m[0]) sb = {sb[6:0], miso_w};
          tick(10);
        end
        chk("slave sent", j ? 8'h3C : 8'hA5, sb);
      end
      tb_ss_n = 1'b1;
      tb_mosi = ~tb_mosi;
      tick(10);
      chk("miso enable", 8'h01, O_MISO_OE);
      chk("rx level", 8'h02, O_RX_LEVEL);
      chk("rx head", 8'hD2, O_RX_DATA);
      chk("rx count irq", 8'h01, O_RX_IRQ);
    end
  endtask
  initial begin
    {I_MASTER_EN, I_CPOL, I_CPHA, I_XFER_INIT_MODE} = 4'h8;
    {I_RX_FLUSH_EN, I_TX_FLUSH_EN, I_TX_WR, I_RX_RD, I_STATUS_RD} = 5'h00;
    {I_DIV, I_TX_DATA, slv_byte} = 24'h040000;
    I_IRQ_BYTES = 2'h0;
    {tb_sclk, tb_mosi, tb_ss_n} = 3'h1;
    t_reset_vals();
    t_master();
    t_underflow();
    t_overflow();
    t_slave();
    wrap_up();
  end
endmodule // ssp_port_tb_top
`default_nettype wire

/* testbench/ssp_slave_model.sv */
// behavioural external slave device on the serial link
`timescale 1ns/1ps
`default_nettype none
module ssp_slave_model (
  input wire logic i_sclk,
  input wire logic i_ss_n,
  input wire logic i_mosi,
  input wire logic i_cpol,
  input wire logic i_cpha,
  input wire logic [7:0] i_byte,
  output logic o_miso,
  output logic [7:0] o_rx
);
  logic [7:0] sh;
  initial begin
    o_miso = 1'b0;
    o_rx = 8'h00;
    sh = 8'h00;
  end
  // a released line holds no value, so show the inverse of the last bit
  always @(posedge i_ss_n) o_miso = ~o_miso;
  always @(negedge i_ss_n) begin
    sh = i_byte;
    if (!i_cpha) o_miso = sh[7];
  end
  always @(i_sclk) begin
    if (!i_ss_n && ((i_sclk != i_cpol) != i_cpha)) begin
      o_rx = {o_rx[6:0], i_mosi};
    end else if (!i_ss_n) begin
      if (!i_cpha) sh = {sh[6:0], 1'b0};
      o_miso = sh[7];
      if (i_cpha) sh = {sh[6:0], 1'b0};
    end
  end
endmodule // ssp_slave_model
`default_nettype wire

/* verilog/ssp_clkdiv.v */
// half-period tick generator for the master serial clock
`timescale 1ns/1ps
`default_nettype none
`include "ssp_consts.vh"
module ssp_clkdiv #(
  parameter W = 8
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_en,
  input wire [W-1:0] i_div,
  output reg o_tick
);
  reg [W-1:0] cnt_r;
  wire [W-1:0] eff;

  // clamp keeps the link rate inside its limit whatever is programmed
  assign eff = (i_div < `SSP_MIN_DIV) ? `SSP_MIN_DIV : i_div;

  // one tick every (1 + div) clocks gives a period of 2 * (1 + div)
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= {W{1'b0}};
      o_tick <= 1'b0;
    end else if (!i_en) begin
      cnt_r <= {W{1'b0}};
      o_tick <= 1'b0;
    end else if (cnt_r >= eff) begin
      cnt_r <= {W{1'b0}};
      o_tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      o_tick <= 1'b0;
    end
  end
endmodule // ssp_clkdiv
`default_nettype wire

/* verilog/ssp_consts.vh */
// constants shared by the serial port block
`ifndef SSP_CONSTS_VH
`define SSP_CONSTS_VH

// byte width and edge count of one transfer
`define SSP_DW 8
`define SSP_EDGE_W 4
`define SSP_EDGE_FIRST 4'h0
`define SSP_EDGE_LAST 4'hF

// byte sent when the transmit queue is empty at transfer start
`define SSP_FILL_BYTE 8'h00

// queue geometry
`define SSP_DEPTH 4
`define SSP_LVL_W 3

// clock and link rate limit, figures in kHz and kbit/s
`define SSP_CLK_KHZ 20000
`define SSP_MAX_KBPS 5120
// least divider so that clk / (2 * (1 + div)) stays under the limit
// ceil(20000 / 10240) - 1 = 1, written out as a sized literal
`define SSP_MIN_DIV 8'h01

// receive bit counter
`define SSP_BIT_W 3
`define SSP_BIT_LAST 3'h7

// interrupt byte count field width
`define SSP_ICNT_W 2

// reset levels
`define SSP_SYNC_LO 3'h0
`define SSP_SYNC_HI 3'h7

`endif

/* verilog/ssp_fifo.v */
// small synchronous queue with level count
`timescale 1ns/1ps
`default_nettype none
module ssp_fifo #(
  parameter W = 8,
  parameter DEPTH = 4,
  parameter LW = 3,
  parameter AW = 2
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_push,
  input wire [W-1:0] i_data,
  input wire i_pop,
  output wire [W-1:0] o_data,
  output wire [LW-1:0] o_level,
  output wire o_full,
  output wire o_empty
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [LW-1:0] lvl_r;
  wire do_push;
  wire do_pop;

  assign o_full = (lvl_r == DEPTH[LW-1:0]);
  assign o_empty = (lvl_r == {LW{1'b0}});
  // push when full and pop when empty are dropped quietly
  assign do_push = i_push & ~o_full;
  assign do_pop = i_pop & ~o_empty;
  assign o_data = mem[rp_r];
  assign o_level = lvl_r;

  always @(posedge i_clk) begin
    if (do_push) begin
      mem[wp_r] <= i_data;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      lvl_r <= {LW{1'b0}};
    end else begin
      if (do_push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (do_pop) begin
        rp_r <= rp_r + 1'b1;
      end
      if (do_push & ~do_pop) begin
        lvl_r <= lvl_r + 1'b1;
      end else if (do_pop & ~do_push) begin
        lvl_r <= lvl_r - 1'b1;
      end
    end
  end
endmodule // ssp_fifo
`default_nettype wire

/* verilog/ssp_port.v */
// serial peripheral port, master or slave, byte wide, full duplex
`timescale 1ns/1ps
`default_nettype none
`include "ssp_consts.vh"
module ssp_port #(
  parameter DEPTH = `SSP_DEPTH,
  parameter DIV_W = 8
) (
  input wire I_MCLK,
  input wire I_RESETN,
  input wire I_MASTER_EN,
  input wire I_CPOL,
  input wire I_CPHA,
  input wire [DIV_W-1:0] I_DIV,
  input wire I_XFER_INIT_MODE,
  input wire I_RX_FLUSH_EN,
  input wire I_TX_FLUSH_EN,
  input wire [`SSP_ICNT_W-1:0] I_IRQ_BYTES,
  input wire I_TX_WR,
  input wire [`SSP_DW-1:0] I_TX_DATA,
  input wire I_RX_RD,
  input wire I_STATUS_RD,
  output reg [`SSP_DW-1:0] O_RX_DATA,
  output reg [`SSP_LVL_W-1:0] O_RX_LEVEL,
  output reg [`SSP_LVL_W-1:0] O_TX_LEVEL,
  output reg O_RX_OVF,
  output reg O_TX_UNF,
  output reg O_RX_IRQ,
  output reg O_TX_IRQ,
  output reg O_IRQ,
  output reg O_BUSY,
  input wire I_SCLK,
  output reg O_SCLK,
  output reg O_SCLK_OE,
  input wire I_MISO,
  output reg O_MISO,
  output reg O_MISO_OE,
  input wire I_MOSI,
  output reg O_MOSI,
  output reg O_MOSI_OE,
  input wire I_SS_N,
  output reg O_SS_N,
  output reg O_SS_N_OE
);
  localparam ST_IDLE = 4'h1;
  localparam ST_SETUP = 4'h2;
  localparam ST_RUN = 4'h4;
  localparam ST_HOLD = 4'h8;

  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [2:0] sclk_s;
  reg [2:0] ss_s;
  reg [1:0] mosi_s;
  reg [1:0] miso_s;
  reg [`SSP_DW-1:0] sh_r;
  reg [`SSP_DW-1:0] rxsh_r;
  reg [1:0] cap_d_r;
  reg [`SSP_BIT_W-1:0] rxb_r;
  reg [`SSP_EDGE_W-1:0] edge_r;
  reg rd_pend_r;
  reg [`SSP_ICNT_W-1:0] bcnt_r;
  reg sclk_m_r;

  wire tick;
  wire master;
  wire slave;
  wire ss_lo;
  wire din;
  wire s_edge;
  wire m_edge;
  wire sedge;
  wire lead;
  wire samp;
  wire launch;
  wire done;
  wire cap;
  wire rx_done;
  wire start;
  wire load;
  wire unf_set;
  wire ovf_set;
  wire [`SSP_DW-1:0] rx_byte;
  wire [`SSP_DW-1:0] tx_head;
  wire [`SSP_DW-1:0] rx_head;
  wire [`SSP_LVL_W-1:0] tx_lvl;
  wire [`SSP_LVL_W-1:0] rx_lvl;
  wire tx_full;
  wire tx_empty;
  wire rx_full;
  wire rx_empty;
  wire cnt_hit;

  assign master = I_MASTER_EN;
  assign slave = ~I_MASTER_EN;
  assign ss_lo = ~ss_s[1];

  // data pins pass two flops, clock and select three; stage 0 feeds stage 1 only
  always @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      sclk_s <= `SSP_SYNC_LO;
      ss_s <= `SSP_SYNC_HI;
      mosi_s <= 2'h0;
      miso_s <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], I_SCLK};
      ss_s <= {ss_s[1:0], I_SS_N};
      mosi_s <= {mosi_s[0], I_MOSI};
      miso_s <= {miso_s[0], I_MISO};
    end
  end

  ssp_clkdiv #(
    .W(DIV_W)
  ) u_div (
    .i_clk(I_MCLK),
    .i_rst_n(I_RESETN),
    .i_en(master & (state_r != ST_IDLE)),
    .i_div(I_DIV),
    .o_tick(tick)
  );

  // slave edges arrive two clocks late, which bounds its rate
  assign s_edge = slave & ss_lo & (sclk_s[1] ^ sclk_s[2]);
  assign m_edge = master & (state_r == ST_RUN) & tick;
  assign sedge = master ? m_edge : s_edge;
  // even edge counts are leading edges, odd ones trailing
  assign lead = ~edge_r[0];
  assign samp = sedge & (I_CPHA ? ~lead : lead);
  assign launch = sedge & (I_CPHA ? (lead & (edge_r != `SSP_EDGE_FIRST))
                                  : ~lead);
  assign din = master ? miso_s[1] : mosi_s[1];
  assign done = sedge & (edge_r == `SSP_EDGE_LAST);
  // a master takes returning data two clocks after its sample edge,
  // covering the output flop and the pin synchroniser
  assign cap = master ? cap_d_r[1] : samp;
  assign rx_done = cap & (rxb_r == `SSP_BIT_LAST);
  assign rx_byte = {rxsh_r[`SSP_DW-2:0], din};

  // master start: queued data, or a receive read in read-started mode
  assign start = master & (state_r == ST_IDLE) &
                 (I_XFER_INIT_MODE ? ~tx_empty : rd_pend_r);
  assign load = start |
                (slave & ss_s[2] & ss_lo) |
                (slave & done & ss_lo);
  assign unf_set = load & tx_empty;
  assign ovf_set = rx_done & rx_full;
  assign cnt_hit = rx_done & (bcnt_r == I_IRQ_BYTES);

  ssp_fifo #(
    .W(`SSP_DW),
    .DEPTH(DEPTH),
    .LW(`SSP_LVL_W),
    .AW(2)
  ) u_txq (
    .i_clk(I_MCLK),
    .i_rst_n(I_RESETN),
    .i_push(I_TX_WR),
    .i_data(I_TX_DATA),
    .i_pop(load),
    .o_data(tx_head),
    .o_level(tx_lvl),
    .o_full(tx_full),
    .o_empty(tx_empty)
  );

  ssp_fifo #(
    .W(`SSP_DW),
    .DEPTH(DEPTH),
    .LW(`SSP_LVL_W),
    .AW(2)
  ) u_rxq (
    .i_clk(I_MCLK),
    .i_rst_n(I_RESETN),
    .i_push(rx_done),
    .i_data(rx_byte),
    .i_pop(I_RX_RD),
    .o_data(rx_head),
    .o_level(rx_lvl),
    .o_full(rx_full),
    .o_empty(rx_empty)
  );

  // master sequencing: select, half-period setup, 16 edges, hold
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start) begin
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (tick) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (done) begin
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (tick) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (!master) begin
      state_nxt = ST_IDLE;
    end
  end

  // shift engine shared by both roles
  always @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state_r <= ST_IDLE;
      sh_r <= `SSP_FILL_BYTE;
      rxsh_r <= `SSP_FILL_BYTE;
      cap_d_r <= 2'h0;
      rxb_r <= {`SSP_BIT_W{1'b0}};
      edge_r <= `SSP_EDGE_FIRST;
      sclk_m_r <= 1'b0;
      rd_pend_r <= 1'b0;
      bcnt_r <= {`SSP_ICNT_W{1'b0}};
    end else begin
      state_r <= state_nxt;
      if (load) begin
        sh_r <= tx_empty ? `SSP_FILL_BYTE : tx_head;
      end else if (launch) begin
        sh_r <= {sh_r[`SSP_DW-2:0], 1'b0};
      end
      cap_d_r <= {cap_d_r[0], samp & master};
      if (start | (slave & ~ss_lo)) begin
        rxb_r <= {`SSP_BIT_W{1'b0}};
      end else if (cap) begin
        rxsh_r <= rx_byte;
        rxb_r <= rxb_r + 1'b1;
      end
      if (slave & ~ss_lo) begin
        edge_r <= `SSP_EDGE_FIRST;
      end else if (sedge) begin
        edge_r <= edge_r + 1'b1;
      end
      if (m_edge) begin
        sclk_m_r <= ~sclk_m_r;
      end else if (state_r == ST_IDLE) begin
        sclk_m_r <= I_CPOL;
      end
      if (start) begin
        rd_pend_r <= 1'b0;
      end else if (I_RX_RD & master & ~I_XFER_INIT_MODE) begin
        rd_pend_r <= 1'b1;
      end
      if (cnt_hit) begin
        bcnt_r <= {`SSP_ICNT_W{1'b0}};
      end else if (rx_done) begin
        bcnt_r <= bcnt_r + 1'b1;
      end
    end
  end

  // status flags: a set in the clearing cycle survives
  always @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_RX_OVF <= 1'b0;
      O_TX_UNF <= 1'b0;
      O_RX_IRQ <= 1'b0;
      O_TX_IRQ <= 1'b0;
      O_IRQ <= 1'b0;
    end else begin
      O_RX_OVF <= ovf_set | (O_RX_OVF & ~I_STATUS_RD);
      O_TX_UNF <= unf_set | (O_TX_UNF & ~I_STATUS_RD);
      O_RX_IRQ <= (cnt_hit & ~I_XFER_INIT_MODE) |
                  (O_RX_IRQ & ~I_STATUS_RD);
      O_TX_IRQ <= (cnt_hit & I_XFER_INIT_MODE) |
                  (O_TX_IRQ & ~I_STATUS_RD);
      O_IRQ <= (ovf_set & ~I_RX_FLUSH_EN) |
               (unf_set & ~I_TX_FLUSH_EN) |
               cnt_hit |
               (O_IRQ & ~I_STATUS_RD);
    end
  end

  // pin drivers lag the shift register by one clock
  always @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_SCLK <= 1'b0;
      O_SCLK_OE <= 1'b0;
      O_MOSI <= 1'b0;
      O_MOSI_OE <= 1'b0;
      O_MISO <= 1'b0;
      O_MISO_OE <= 1'b0;
      O_SS_N <= 1'b1;
      O_SS_N_OE <= 1'b0;
      O_RX_DATA <= `SSP_FILL_BYTE;
      O_RX_LEVEL <= {`SSP_LVL_W{1'b0}};
      O_TX_LEVEL <= {`SSP_LVL_W{1'b0}};
      O_BUSY <= 1'b0;
    end else begin
      O_SCLK <= sclk_m_r;
      O_SCLK_OE <= master;
      O_MOSI <= sh_r[`SSP_DW-1];
      O_MOSI_OE <= master;
      O_MISO <= sh_r[`SSP_DW-1];
      O_MISO_OE <= slave;
      O_SS_N <= ~(master & (state_r != ST_IDLE));
      O_SS_N_OE <= master;
      O_RX_DATA <= rx_empty ? `SSP_FILL_BYTE : rx_head;
      O_RX_LEVEL <= rx_lvl;
      O_TX_LEVEL <= tx_lvl;
      O_BUSY <= master ? (state_r != ST_IDLE) : ss_lo;
    end
  end
endmodule // ssp_port
`default_nettype wire
